/* rtl/lds_core.sv */
// lds_core: 49-bit common shift register, on/off latch, setting latches and blanking.
// assumes shift clock, strobe, serial data and blanking are pins slower than clk_in / 4.
`timescale 1ns/1ps

// Operation
// - on each shift clock rise, serial input level enters the shift LSB.
// - each shift clock rise moves all shift bits one place toward MSB.
// - serial output is the shift register MSB, for cascading.
// - strobe rise copies shift register into on/off latch or setting latch.
// - blanking high forces every sink output off.
// - blanking low drives each output from its on/off latch bit.
// - 48 outputs as red, green, blue groups of 16, all gated.
module lds_core import lds_pkg::*; (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // serial pins
    input  wire logic                  serial_in,
    input  wire logic                  shift_clk_in,
    input  wire logic                  latch_strobe_in,
    input  wire logic                  blank_in,
    output logic                       serial_out,
    // status words offered for readback
    input  wire logic [SHIFT_W-1:0]    status_word0_in,
    input  wire logic [SHIFT_W-1:0]    status_word1_in,
    input  wire logic [SHIFT_W-1:0]    status_word2_in,
    input  wire logic [SHIFT_W-1:0]    status_word3_in,
    // sink outputs and settings
    output logic [GROUP_CH-1:0]        led_sink_red_out,
    output logic [GROUP_CH-1:0]        led_sink_green_out,
    output logic [GROUP_CH-1:0]        led_sink_blue_out,
    output logic [MC_W-1:0]            max_current_setting_out,
    output logic [BC_W-1:0]            group_brightness_red_out,
    output logic [BC_W-1:0]            group_brightness_green_out,
    output logic [BC_W-1:0]            group_brightness_blue_out,
    output logic [FC_W-1:0]            function_setting_out,
    output logic [SSEL_W-1:0]          status_select_setting_out
);

    // edge finder for a synchronised pin level
    function automatic logic rise_of(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rise_of

    // status word chosen by the select setting
    function automatic logic [SHIFT_W-1:0] pick_status(
        input logic [SSEL_W-1:0]  sel,
        input logic [SHIFT_W-1:0] w0,
        input logic [SHIFT_W-1:0] w1,
        input logic [SHIFT_W-1:0] w2,
        input logic [SHIFT_W-1:0] w3
    );
        logic [SHIFT_W-1:0] pick;
        unique case (sel)
            2'h0: pick = w0;
            2'h1: pick = w1;
            2'h2: pick = w2;
            2'h3: pick = w3;
        endcase
        return pick;
    endfunction : pick_status

    // one colour group of sixteen channels
    function automatic logic [GROUP_CH-1:0] group_of(
        input logic [NUM_CH-1:0] vec,
        input int                grp
    );
        return vec[grp*GROUP_CH +: GROUP_CH];
    endfunction : group_of

    // synchronised pin levels
    logic                 sclk_s;
    logic                 lat_s;
    logic                 sin_s;
    logic                 blank_s;

    // previous synchronised levels, for edge finding
    logic                 sclk_d;
    logic                 lat_d;

    // shift register and latches
    logic [SHIFT_W-1:0]   shift_reg;
    logic [NUM_CH-1:0]    onoff;
    logic [CFG_W-1:0]     cfg;

    // gated sink state, one register per colour group
    logic [GROUP_CH-1:0]  sink_red;
    logic [GROUP_CH-1:0]  sink_green;
    logic [GROUP_CH-1:0]  sink_blue;

    // next values
    logic [SHIFT_W-1:0]   next_shift;
    logic [NUM_CH-1:0]    next_onoff;
    logic [CFG_W-1:0]     next_cfg;
    logic [NUM_CH-1:0]    next_sink;

    // every pin passes two flops before any logic reads it
    lds_sync u_sclk (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (shift_clk_in),
        .q_out  (sclk_s)
    );

    lds_sync u_lat (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (latch_strobe_in),
        .q_out  (lat_s)
    );

    lds_sync u_sin (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (serial_in),
        .q_out  (sin_s)
    );

    lds_sync u_blank (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (blank_in),
        .q_out  (blank_s)
    );

    // edge and destination decode
    wire                sclk_rise = rise_of(sclk_s, sclk_d);
    wire                lat_rise  = rise_of(lat_s, lat_d);
    wire                sel_cfg   = shift_reg[SEL_BIT];
    wire                to_onoff  = lat_rise & ~sel_cfg;
    wire                to_cfg    = lat_rise & sel_cfg;

    // status readback select
    wire [SSEL_W-1:0]   ssel       = cfg[SSEL_LSB +: SSEL_W];
    wire [SHIFT_W-1:0]  status_sel = pick_status(ssel, status_word0_in, status_word1_in,
                                                 status_word2_in, status_word3_in);

    // new bit enters at the bottom, the rest move toward the top
    wire [SHIFT_W-1:0]  shifted    = {shift_reg[SHIFT_W-2:0], sin_s};

    // strobe reload wins over a coincident shift edge; host spaces them anyway
    assign next_shift = to_onoff  ? status_sel :
                        sclk_rise ? shifted    : shift_reg;
    assign next_onoff = to_onoff ? shift_reg[NUM_CH-1:0] : onoff;
    assign next_cfg   = to_cfg ? shift_reg[CFG_W-1:0] : cfg;

    // blanking is resynchronised, so outputs lag the pin by three clocks
    assign next_sink  = blank_s ? ONOFF_RST : onoff;

    // edge history
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sclk_d <= 1'h0;
            lat_d  <= 1'h0;
        end else begin
            sclk_d <= sclk_s;
            lat_d  <= lat_s;
        end
    end

    // common shift register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shift_reg <= SHIFT_RST;
        end else begin
            shift_reg <= next_shift;
        end
    end

    // on/off latch
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            onoff <= ONOFF_RST;
        end else begin
            onoff <= next_onoff;
        end
    end

    // setting latch, select bits included
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg <= CFG_RST;
        end else begin
            cfg <= next_cfg;
        end
    end

    // red sinks
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sink_red <= GROUP_RST;
        end else begin
            sink_red <= group_of(next_sink, 0);
        end
    end

    // green sinks
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sink_green <= GROUP_RST;
        end else begin
            sink_green <= group_of(next_sink, 1);
        end
    end

    // blue sinks
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sink_blue <= GROUP_RST;
        end else begin
            sink_blue <= group_of(next_sink, 2);
        end
    end

    // outputs
    assign serial_out                 = shift_reg[SHIFT_W-1];
    assign led_sink_red_out           = sink_red;
    assign led_sink_green_out         = sink_green;
    assign led_sink_blue_out          = sink_blue;
    assign max_current_setting_out    = cfg[MC_LSB +: MC_W];
    assign group_brightness_red_out   = cfg[BC_R_LSB +: BC_W];
    assign group_brightness_green_out = cfg[BC_G_LSB +: BC_W];
    assign group_brightness_blue_out  = cfg[BC_B_LSB +: BC_W];
    assign function_setting_out       = cfg[FC_LSB +: FC_W];
    assign status_select_setting_out  = ssel;
endmodule : lds_core

/* rtl/lds_pkg.sv */
// lds_pkg: constants for the serial shift/latch front end of a 48-channel led sink driver.
// assumes one system clock; shift clock and strobe arrive as pins and are sampled.
package lds_pkg;
    localparam int SHIFT_W       = 49;
    localparam int GROUP_CH      = 16;
    localparam int NUM_GROUPS    = 3;
    localparam int NUM_CH        = GROUP_CH * NUM_GROUPS;
    localparam int SEL_BIT       = 48;
    localparam int MC_LSB        = 0;
    localparam int MC_W          = 3;
    localparam int BC_R_LSB      = 3;
    localparam int BC_G_LSB      = 10;
    localparam int BC_B_LSB      = 17;
    localparam int BC_W          = 7;
    localparam int FC_LSB        = 24;
    localparam int FC_W          = 16;
    localparam int SSEL_LSB      = 40;
    localparam int SSEL_W        = 2;
    localparam logic [48:0] SHIFT_RST = 49'h0_0000_0000_0000;
    localparam logic [47:0] ONOFF_RST = 48'h0000_0000_0000;
    localparam int CFG_W         = 42;
    localparam logic [41:0] CFG_RST   = 42'h000_0000_0000;
    localparam logic [15:0] GROUP_RST = 16'h0000;
endpackage : lds_pkg

/* rtl/lds_sync.sv */
// lds_sync: two-flop synchroniser for a level arriving from a pin.
// assumes d_in is asynchronous to clk_in.
`timescale 1ns/1ps
module lds_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // level
    input  wire logic d_in,
    output logic      q_out
);
    logic meta;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta  <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : lds_sync

/* tb/lds_host.sv */
// lds_host: display controller model; send starts just after a falling clk_in edge
`timescale 1ns/1ps
module lds_host (input wire logic clk_in, serial_out,
    output logic serial_in = 0, shift_clk_in = 0, latch_strobe_in = 0);
    // msb first, 3-clock low and 4-clock high phases; r returns what came back on serial_out
    task automatic send(input logic [48:0] w, output logic [48:0] r);
        for (int i = 48; i >= 0; i--) begin
            serial_in = w[i]; // held 3 clocks before and 4 after the rise
            repeat (3) @(negedge clk_in);
            r = {r[47:0], serial_out};
            shift_clk_in = 1; repeat (4) @(negedge clk_in);
            shift_clk_in = 0;
        end
        serial_in = ~w[0]; // idle line never shows a stale bit
        repeat (3) @(negedge clk_in);
        latch_strobe_in = 1; repeat (4) @(negedge clk_in);
        latch_strobe_in = 0; repeat (8) @(negedge clk_in);
    endtask : send
endmodule : lds_host

/* tb/lds_monitor.sv */
// lds_monitor: port checks for lds_core; pins move on falling clk_in edges
`timescale 1ns/1ps
module lds_monitor (input wire logic clk_in, rst_in, shift_clk_in, latch_strobe_in,
    input wire logic blank_in, serial_out, input wire logic [2:0] max_current_setting_out,
    input wire logic [15:0] led_sink_red_out, led_sink_green_out, led_sink_blue_out,
    input wire logic [15:0] function_setting_out);
    logic [6:0] sk, lk, bk; // pins act 3 to 6 clocks late, so look back that far
    always_ff @(posedge clk_in) {sk, lk, bk} <= {sk[5:0], shift_clk_in,
        lk[5:0], latch_strobe_in, bk[5:0], blank_in};
    wire sev = |(sk[5:2] & ~sk[6:3]), lev = |(lk[5:2] & ~lk[6:3]), bev = |(bk[5:2] ^ bk[6:3]);
    wire [47:0] snk = {led_sink_blue_out, led_sink_green_out, led_sink_red_out};
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_serial_out_event: assert property ($changed(serial_out) |-> sev || lev) else $error("serial_out");
    a_blank_off: assert property (blank_in [*7] |-> snk == 0) else $error("lit");
    a_sink_gate: assert property (|snk |-> !(&bk[6:2])) else $error("lit");
    a_red_follow: assert property ($changed(led_sink_red_out) |-> lev || bev) else $error("r");
    a_grn_follow: assert property ($changed(led_sink_green_out) |-> lev || bev) else $error("g");
    a_blu_follow: assert property ($changed(led_sink_blue_out) |-> lev || bev) else $error("b");
    a_mc_latch: assert property ($changed(max_current_setting_out) |-> lev) else $error("mc");
    a_fc_latch: assert property ($changed(function_setting_out) |-> lev) else $error("fc");
endmodule : lds_monitor
bind lds_core lds_monitor u_mon (.*);

/* tb/test_led_driver_serial_shift_latch.sv */
// test_led_driver_serial_shift_latch: table bench; lds_host drives the serial, shift clock and strobe pins
`timescale 1ns/1ps
module test_led_driver_serial_shift_latch;
    logic clk_in = 0, rst_in = 1, blank_in = 0, serial_in, shift_clk_in, latch_strobe_in;
    logic serial_out;
    logic [48:0] status_word0_in = 49'h1_2345_6789_abcd, status_word1_in = 49'h0_0f0f_1234_5678;
    logic [48:0] status_word2_in = 0, status_word3_in = 0, rd, ex = 0;
    logic [15:0] led_sink_red_out, led_sink_green_out, led_sink_blue_out, function_setting_out;
    logic [6:0] group_brightness_red_out, group_brightness_green_out, group_brightness_blue_out;
    logic [2:0] max_current_setting_out;
    logic [1:0] status_select_setting_out;
    logic [48:0] rows [5] = '{49'h0_ffff_0000_a5a5, 49'h1_00ab_cd12_3457,
        49'h1_01ff_ffff_ffff, 49'h0_8001_7ffe_0001, 49'h0_5a5a_c3c3_0ff0};
    logic [1:0] ss = 0;
    int failures = 0, n_checks = 0, cyc = 0;
    wire [48:0] onoff = {1'b0, led_sink_blue_out, led_sink_green_out, led_sink_red_out};
    wire [48:0] cfg = {7'h0, status_select_setting_out, function_setting_out,
        group_brightness_blue_out, group_brightness_green_out, group_brightness_red_out,
        max_current_setting_out};
    lds_host host (.*);
    lds_core DUT (.*);
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cyc == 4000) begin failures++; conclude(); end
    task automatic chk(input logic [48:0] s, e);
        n_checks++;
        if (s !== e) begin failures++; $display("[FAIL] %0t seen %h exp %h", $time, s, e); end
    endtask : chk
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(negedge clk_in);
        rst_in = 0;
        chk(onoff | cfg | serial_out, 0);
        for (int i = 0; i < 5; i++) begin
            host.send(rows[i], rd);
            chk(rd, ex);
            chk(rows[i][48] ? cfg : onoff,
                rows[i] & (rows[i][48] ? 49'h3ff_ffff_ffff : '1));
            ss = rows[i][48] ? rows[i][41:40] : ss;
            ex = rows[i][48] ? rows[i] : ss == 0 ? status_word0_in : ss == 1 ? status_word1_in
                : ss == 2 ? status_word2_in : status_word3_in;
        end
        blank_in = 1; repeat (8) @(negedge clk_in);
        chk(onoff, 0);
        blank_in = 0; repeat (8) @(negedge clk_in);
        chk(onoff, rows[4]);
        rst_in = 1; repeat (2) @(negedge clk_in);
        rst_in = 0;
        chk(onoff | cfg | serial_out, 0);
        host.send(rows[0], rd);
        chk(rd, 0);
        chk(onoff, rows[0]);
        conclude();
    end
endmodule : test_led_driver_serial_shift_latch
